// ### verilog/cgi_pkg.sv
// constants shared by the pin and interrupt unit
// assumes 8-bit register indices and 16-bit register data
package cgi_pkg;

	// ********************************
	// register indices
	// ********************************
	localparam logic [7:0] OFS_PIN_MODE = 8'h0b;
	localparam logic [7:0] OFS_PIN1_CTRL = 8'h0c;
	localparam logic [7:0] OFS_PIN2_CTRL = 8'h0d;
	localparam logic [7:0] OFS_PIN3_CTRL = 8'h0e;
	localparam logic [7:0] OFS_PIN4_CTRL = 8'h0f;
	localparam logic [7:0] OFS_INT_STATUS = 8'h10;
	localparam logic [7:0] OFS_FAULT_FLAGS = 8'h11;
	localparam logic [7:0] OFS_IRQ_CFG = 8'h12;
	localparam logic [7:0] OFS_INT_MASK = 8'h13;

	// ********************************
	// field positions
	// ********************************
	localparam int BIT_DIRECTION = 15;
	localparam int BIT_PULL_HI = 14;
	localparam int BIT_PULL_LO = 13;
	localparam int BIT_EDGE_MODE = 12;
	localparam int BIT_INVERT = 10;
	localparam int BIT_LEVEL = 5;
	localparam int BIT_FN_HI = 3;
	localparam int BIT_THERMAL = 15;
	localparam int BIT_PIN1_IRQ = 11;
	localparam int BIT_REGLOW = 0;
	localparam int BIT_MODE_SEL = 0;
	localparam int BIT_OUT_MASK = 0;
	localparam logic [15:0] STATUS_USED = 16'hf801;

	// ********************************
	// codes
	// ********************************
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [3:0] FN_LEVEL_IN = 4'h0;
	localparam logic [3:0] FN_EDGE_IN = 4'h1;
	localparam logic [3:0] FN_CLK_OUT = 4'h2;
	localparam logic [3:0] FN_IRQ_OUT = 4'h3;
	localparam logic [3:0] FN_TEMP_OUT = 4'h7;
	localparam logic [3:0] FN_MIC_CLK = 4'h9;
	localparam logic [3:0] FN_LEVEL_OUT = 4'ha;
	localparam logic [3:0] FN_REGLOW_OUT = 4'hb;

	// ********************************
	// reset values
	// ********************************
	localparam logic RST_DIRECTION = 1'b1;
	localparam logic RST_OUT_MASK = 1'b1;
	localparam logic RST_MODE_SEL = 1'b0;
	localparam logic [15:0] RST_INT_MASK = 16'h0000;

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction

	function automatic logic is_drive_fn(input logic [3:0] fn);
		is_drive_fn = (fn == FN_CLK_OUT) || (fn == FN_IRQ_OUT) || (fn == FN_TEMP_OUT) ||
			(fn == FN_MIC_CLK) || (fn == FN_LEVEL_OUT) || (fn == FN_REGLOW_OUT);
	endfunction

endpackage

// ### verilog/cgi_pin_cell.sv
// one general purpose pin: control register, edge detection, output select
// assumes pin input synchronous to clk; slow_tick is a one-cycle pulse
`timescale 1ns/100ps
module cgi_pin_cell
	import cgi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic soft_rst,
	input wire logic ctrl_wr,
	input wire logic [15:0] wdata,
	input wire logic available,
	input wire logic pin_in,
	input wire logic slow_tick,
	input wire logic timeout_clock_enable,
	input wire logic irq_line,
	input wire logic divided_clock_output,
	input wire logic mic_clock_output,
	input wire logic overtemp_flag,
	input wire logic regulator_low_flag,
	output logic [15:0] ctrl_rdata,
	output logic edge_event,
	output logic pin_out,
	output logic pin_oe_n,
	output logic pull_up,
	output logic pull_down
);

	logic direction;
	logic [1:0] pull_select;
	logic edge_mode;
	logic invert;
	logic level_out;
	logic [3:0] function_sel;
	logic prev_adj;
	logic level_seen;

	// ********************************
	// decode
	// ********************************
	wire adj = pin_in ^ invert; // [RULE_04]
	wire edge_active = available & direction & (function_sel == FN_EDGE_IN); // [RULE_06]
	wire rise = adj & ~prev_adj; // [RULE_02]
	wire change = adj ^ prev_adj; // [RULE_03]
	wire next_edge = edge_active & (edge_mode ? change : rise); // [RULE_02] [RULE_03]
	wire drives = available & ~direction & is_drive_fn(function_sel); // [RULE_14]
	wire src_raw = (function_sel == FN_CLK_OUT) ? divided_clock_output : // [RULE_08]
		(function_sel == FN_IRQ_OUT) ? irq_line : // [RULE_07]
		(function_sel == FN_TEMP_OUT) ? overtemp_flag : // [RULE_09]
		(function_sel == FN_MIC_CLK) ? mic_clock_output : // [RULE_08]
		(function_sel == FN_REGLOW_OUT) ? regulator_low_flag : level_out; // [RULE_09] [RULE_05]
	wire next_pin_out = drives & (src_raw ^ invert); // [RULE_04]
	// level reads are refreshed only on the gated slow tick
	wire next_level_seen = (slow_tick & timeout_clock_enable) ? adj : level_seen; // [RULE_17]

	assign ctrl_rdata = {direction, pull_select, edge_mode, 1'b0, invert, 4'h0,
		level_seen, 1'b0, function_sel}; // [RULE_05]

	// ********************************
	// control register
	// ********************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			direction <= RST_DIRECTION;
			pull_select <= PULL_NONE;
			edge_mode <= 1'b0;
			invert <= 1'b0;
			level_out <= 1'b0;
			function_sel <= FN_LEVEL_IN;
		end else if (ce && soft_rst) begin
			direction <= RST_DIRECTION;
			pull_select <= PULL_NONE;
			edge_mode <= 1'b0;
			invert <= 1'b0;
			level_out <= 1'b0;
			function_sel <= FN_LEVEL_IN;
		end else if (ce && ctrl_wr) begin
			direction <= wdata[BIT_DIRECTION]; // [RULE_14]
			pull_select <= wdata[BIT_PULL_HI:BIT_PULL_LO];
			edge_mode <= wdata[BIT_EDGE_MODE];
			invert <= wdata[BIT_INVERT];
			level_out <= wdata[BIT_LEVEL]; // [RULE_05]
			function_sel <= wdata[BIT_FN_HI:0];
		end
	end

	// ********************************
	// pin state
	// ********************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_adj <= 1'b0;
			level_seen <= 1'b0;
			edge_event <= 1'b0;
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
			pull_up <= 1'b0;
			pull_down <= 1'b0;
		end else if (ce) begin
			prev_adj <= adj;
			level_seen <= next_level_seen;
			edge_event <= next_edge;
			pin_out <= next_pin_out;
			pin_oe_n <= ~drives;
			pull_up <= available & (pull_select == PULL_UP); // [RULE_01]
			pull_down <= available & (pull_select == PULL_DOWN); // [RULE_01]
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_pull_decode: assert property (ce |=> (pull_up == ($past(available) && // [RULE_01]
		$past(pull_select) == PULL_UP)) && !(pull_up && pull_down))
		else $error("pull outputs disagree with pull select");

	chk_drive_polarity: assert property ((ce && drives && function_sel == FN_LEVEL_OUT) // [RULE_04]
		|=> pin_out == ($past(level_out) ^ $past(invert)) && !pin_oe_n)
		else $error("driven level ignores invert");

endmodule

// ### verilog/cgi_gpio_irq.sv
// pin and interrupt unit: register file, pins, sticky status, irq output
// assumes one register access per cycle; inputs synchronous to REF_CLK
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: pull code 00 gives no pull, 01 a pull-down, 10 a pull-up, and 11 is reserved.
// RULE_02: in single-edge mode a pin interrupts on rising edge, or falling edge when inverted.
// RULE_03: in dual-edge mode a pin interrupts on every edge regardless of polarity.
// RULE_04: with invert set the level bit is the inverse of the pin for reads and drives.
// RULE_05: writing the level bit sets the driven value and reading it returns the input level.
// RULE_06: function 0000 is a plain level input and 0001 an edge-detection input.
// RULE_07: function 0011 drives the combined interrupt request onto the pin.
// RULE_08: function 0010 drives the divided clock and 1001 the microphone clock.
// RULE_09: functions 1010, 0111 and 1011 drive the level bit, overtemp and undervoltage flags.
// RULE_10: pin-mode bit 0 selects the third pin once set and stays set until soft reset.
// RULE_11: status bits latch when set and clear when the status register is read.
// RULE_12: the mask register has one bit per source where 1 masks that source.
// RULE_13: a global mask bit, set at reset, suppresses the interrupt output while it is 1.
// RULE_14: pin control bit 15 makes the pin an output at 0 and an input at 1, input at reset.
// RULE_15: the fault flag register shows live overtemp at bit 15 and undervoltage at bit 0.
// RULE_16: the interrupt output is high while any unmasked status bit is set and not globally masked.
// RULE_17: the timeout clock enable gates the slow tick used for level detection.
module cgi_gpio_irq
	import cgi_pkg::*;
#(
	parameter int PIN_COUNT = 4
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic SOFT_RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	input wire logic [3:0] PIN_IN,
	output logic [3:0] PIN_OUT,
	output logic [3:0] PIN_OE_N,
	output logic [3:0] PIN_PULL_UP,
	output logic [3:0] PIN_PULL_DOWN,
	output logic CONTROL_PORT_MODE_PIN,
	input wire logic OVERTEMP,
	input wire logic REGULATOR_LOW,
	input wire logic DIVIDED_CLOCK,
	input wire logic MIC_CLOCK,
	input wire logic TIMEOUT_CLOCK_ENABLE,
	input wire logic SLOW_TICK,
	output logic IRQ
);
	import cgi_pkg::*;

	logic pin_mode_select;
	logic irq_output_mask;
	logic [15:0] irq_mask;
	logic [15:0] irq_status;
	logic prev_overtemp;
	logic prev_reglow;
	logic [3:0] pin_events;
	logic [15:0] pin_rdata [4];

	// ********************************
	// address decode
	// ********************************
	wire wr_mode = REG_WR & addr_hit(REG_ADDR, OFS_PIN_MODE);
	wire wr_irq_cfg = REG_WR & addr_hit(REG_ADDR, OFS_IRQ_CFG);
	wire wr_mask = REG_WR & addr_hit(REG_ADDR, OFS_INT_MASK);
	wire rd_status = REG_RD & addr_hit(REG_ADDR, OFS_INT_STATUS);
	wire rd_fault = REG_RD & addr_hit(REG_ADDR, OFS_FAULT_FLAGS);

	// ********************************
	// interrupt sources
	// ********************************
	wire thermal_rise = OVERTEMP & ~prev_overtemp;
	wire reglow_rise = REGULATOR_LOW & ~prev_reglow;
	wire [15:0] event_vec = {thermal_rise, pin_events, 10'h000, reglow_rise}; // [RULE_11]
	wire [15:0] clr_vec = rd_status ? STATUS_USED : 16'h0000; // [RULE_11]
	// a source firing during the read survives the clear
	wire [15:0] next_status = (irq_status & ~clr_vec) | event_vec; // [RULE_11]
	wire irq_pending = |(irq_status & ~irq_mask); // [RULE_12] [RULE_16]
	wire next_irq = irq_pending & ~irq_output_mask; // [RULE_13] [RULE_16]
	wire [15:0] fault_word = {OVERTEMP, 14'h0000, REGULATOR_LOW}; // [RULE_15]
	// once set, only a soft reset or power-off returns the third pin to the strap
	wire next_mode_sel = pin_mode_select | (wr_mode & REG_WDATA[BIT_MODE_SEL]); // [RULE_10]

	// ********************************
	// read mux
	// ********************************
	wire [15:0] rd_mux = addr_hit(REG_ADDR, OFS_PIN_MODE) ? {15'h0000, pin_mode_select} :
		addr_hit(REG_ADDR, OFS_PIN1_CTRL) ? pin_rdata[0] :
		addr_hit(REG_ADDR, OFS_PIN2_CTRL) ? pin_rdata[1] :
		addr_hit(REG_ADDR, OFS_PIN3_CTRL) ? pin_rdata[2] :
		addr_hit(REG_ADDR, OFS_PIN4_CTRL) ? pin_rdata[3] :
		addr_hit(REG_ADDR, OFS_INT_STATUS) ? irq_status :
		addr_hit(REG_ADDR, OFS_FAULT_FLAGS) ? fault_word :
		addr_hit(REG_ADDR, OFS_IRQ_CFG) ? {15'h0000, irq_output_mask} :
		addr_hit(REG_ADDR, OFS_INT_MASK) ? irq_mask : 16'h0000;

	// ********************************
	// pins
	// ********************************
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		// the third pin is the control port mode strap until released
		wire available = (i != 2) || pin_mode_select; // [RULE_10]
		wire ctrl_wr = REG_WR & addr_hit(REG_ADDR, OFS_PIN1_CTRL + 8'(i));
		cgi_pin_cell u_cell (
			.clk(REF_CLK),
			.rst_n(RST_N),
			.ce(CLK_EN),
			.soft_rst(SOFT_RESET),
			.ctrl_wr(ctrl_wr),
			.wdata(REG_WDATA),
			.available(available),
			.pin_in(PIN_IN[i]),
			.slow_tick(SLOW_TICK),
			.timeout_clock_enable(TIMEOUT_CLOCK_ENABLE),
			.irq_line(IRQ),
			.divided_clock_output(DIVIDED_CLOCK),
			.mic_clock_output(MIC_CLOCK),
			.overtemp_flag(OVERTEMP),
			.regulator_low_flag(REGULATOR_LOW),
			.ctrl_rdata(pin_rdata[i]),
			.edge_event(pin_events[i]),
			.pin_out(PIN_OUT[i]),
			.pin_oe_n(PIN_OE_N[i]),
			.pull_up(PIN_PULL_UP[i]),
			.pull_down(PIN_PULL_DOWN[i])
		);
	end

	// ********************************
	// configuration registers
	// ********************************
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_mode_select <= RST_MODE_SEL;
			irq_output_mask <= RST_OUT_MASK;
			irq_mask <= RST_INT_MASK;
		end else if (CLK_EN && SOFT_RESET) begin
			pin_mode_select <= RST_MODE_SEL;
			irq_output_mask <= RST_OUT_MASK;
			irq_mask <= RST_INT_MASK;
		end else if (CLK_EN) begin
			pin_mode_select <= next_mode_sel; // [RULE_10]
			if (wr_irq_cfg) begin
				irq_output_mask <= REG_WDATA[BIT_OUT_MASK]; // [RULE_13]
			end
			if (wr_mask) begin
				irq_mask <= REG_WDATA & STATUS_USED; // [RULE_12]
			end
		end
	end

	// ********************************
	// status and outputs
	// ********************************
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_status <= 16'h0000;
			prev_overtemp <= 1'b0;
			prev_reglow <= 1'b0;
			IRQ <= 1'b0;
			REG_RDATA <= 16'h0000;
			CONTROL_PORT_MODE_PIN <= 1'b0;
		end else if (CLK_EN && SOFT_RESET) begin
			irq_status <= 16'h0000;
			prev_overtemp <= OVERTEMP;
			prev_reglow <= REGULATOR_LOW;
			IRQ <= 1'b0;
			REG_RDATA <= 16'h0000;
			CONTROL_PORT_MODE_PIN <= 1'b0;
		end else if (CLK_EN) begin
			irq_status <= next_status; // [RULE_11]
			prev_overtemp <= OVERTEMP;
			prev_reglow <= REGULATOR_LOW;
			IRQ <= next_irq; // [RULE_16]
			if (REG_RD) begin
				REG_RDATA <= rd_mux; // [RULE_15]
			end
			CONTROL_PORT_MODE_PIN <= PIN_IN[2] & ~pin_mode_select;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_masked_twice;
		(irq_output_mask && CLK_EN && !SOFT_RESET)[*2];
	endsequence

	sequence s_fault_read;
		CLK_EN && rd_fault && !SOFT_RESET;
	endsequence

	chk_status_clear_read: assert property ((CLK_EN && rd_status && !SOFT_RESET // [RULE_11]
		&& event_vec == 16'h0000) |=> irq_status == 16'h0000)
		else $error("status not cleared by read");

	chk_status_sticky: assert property ((CLK_EN && !rd_status) // [RULE_11]
		|=> (irq_status & $past(irq_status)) == $past(irq_status) || $past(SOFT_RESET))
		else $error("status bit dropped without a read");

	chk_set_beats_clear: assert property ((CLK_EN && rd_status && !SOFT_RESET) // [RULE_11]
		|=> (irq_status & $past(event_vec)) == $past(event_vec))
		else $error("event lost during status read");

	chk_irq_output_gate: assert property ((CLK_EN && !SOFT_RESET) // [RULE_16]
		|=> IRQ == ($past(irq_pending) && !$past(irq_output_mask)))
		else $error("irq output does not follow unmasked status");

	chk_global_mask_hold: assert property (s_masked_twice |-> !IRQ) // [RULE_13]
		else $error("irq output high while globally masked");

	chk_mode_latch: assert property ((pin_mode_select && !(CLK_EN && SOFT_RESET)) // [RULE_10]
		|=> pin_mode_select)
		else $error("pin mode select released without soft reset");

	chk_fault_read_live: assert property (s_fault_read // [RULE_15]
		|=> REG_RDATA == {$past(OVERTEMP), 14'h0000, $past(REGULATOR_LOW)})
		else $error("fault flag read mismatch");

	chk_mask_gates: assert property ((CLK_EN && !SOFT_RESET && irq_mask == STATUS_USED) // [RULE_12]
		|=> !IRQ)
		else $error("masked source reached irq output");

endmodule

// ### dv/cgi_pin_partner.sv
// far side of the four general purpose pins: wire resolution per pin
// assumes device enables are active low and the bench drives ext_en/ext_val
`timescale 1ns/100ps
module cgi_pin_partner (
	input wire logic clk,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe_n,
	input wire logic [3:0] pull_up,
	input wire logic [3:0] pull_down,
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext_val,
	output logic [3:0] pin_level
);
	// ********************************
	// wire resolution
	// ********************************
	logic [3:0] last = 4'h0;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!pin_oe_n[i])
				pin_level[i] = pin_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (pull_up[i])
				pin_level[i] = 1'b1;
			else if (pull_down[i])
				pin_level[i] = 1'b0;
			else
				pin_level[i] = ~last[i]; // floating: never shows a stale level
		end
	end
	always_ff @(posedge clk) begin
		last <= pin_level;
	end
endmodule

// ### dv/tb_top.sv
// self-checking bench for the pin and interrupt unit
// assumes the partner model resolves every pin wire into PIN_IN
`timescale 1ns/100ps
module tb_top;
	import cgi_pkg::*;
	logic REF_CLK, RST_N, CLK_EN, SOFT_RESET, REG_WR, REG_RD, IRQ, CONTROL_PORT_MODE_PIN;
	logic OVERTEMP, REGULATOR_LOW, DIVIDED_CLOCK, MIC_CLOCK, TIMEOUT_CLOCK_ENABLE, SLOW_TICK;
	logic [7:0] REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA, rd;
	logic [3:0] PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULL_UP, PIN_PULL_DOWN, ext_en, ext_val;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	cgi_gpio_irq cgi_gpio_irq_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
		.SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
		.PIN_OE_N(PIN_OE_N), .PIN_PULL_UP(PIN_PULL_UP), .PIN_PULL_DOWN(PIN_PULL_DOWN),
		.CONTROL_PORT_MODE_PIN(CONTROL_PORT_MODE_PIN), .OVERTEMP(OVERTEMP),
		.REGULATOR_LOW(REGULATOR_LOW), .DIVIDED_CLOCK(DIVIDED_CLOCK), .MIC_CLOCK(MIC_CLOCK),
		.TIMEOUT_CLOCK_ENABLE(TIMEOUT_CLOCK_ENABLE), .SLOW_TICK(SLOW_TICK), .IRQ(IRQ));
	cgi_pin_partner cgi_pin_partner_inst (.clk(REF_CLK), .pin_out(PIN_OUT),
		.pin_oe_n(PIN_OE_N), .pull_up(PIN_PULL_UP), .pull_down(PIN_PULL_DOWN),
		.ext_en(ext_en), .ext_val(ext_val), .pin_level(PIN_IN));
	// ********************************
	// clock, timeout, helpers
	// ********************************
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	// whole run needs well under a thousand cycles
	always @(posedge REF_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			$display("[ERR] %0t run hung", $time);
			complete_run();
		end
	end
	task automatic complete_run();
		$display("mismatches %0d of %0d checks", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge REF_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [7:0] a);
		@(posedge REF_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1;
	endtask
	task automatic rd_cmp(input logic [7:0] a, input logic [15:0] exp, input string what);
		reg_rd(a);
		cmp_reg(REG_RDATA, exp, what);
	endtask
	task automatic set_pin(input int i, input logic v);
		@(posedge REF_CLK);
		ext_val[i] <= v;
		cyc(4);
	endtask
	task automatic tick();
		@(posedge REF_CLK);
		SLOW_TICK <= 1'b1;
		@(posedge REF_CLK);
		SLOW_TICK <= 1'b0;
		cyc(2);
	endtask
	function automatic logic [15:0] ctl(input logic dir, input logic [1:0] pull,
		input logic mode, input logic inv, input logic lvl, input logic [3:0] fn);
		ctl = {dir, pull, mode, 1'b0, inv, 4'h0, lvl, 1'b0, fn};
	endfunction
	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		rd_cmp(OFS_PIN1_CTRL, 16'h8000, "pin1 ctl");
		rd_cmp(OFS_PIN4_CTRL, 16'h8000, "pin4 ctl");
		rd_cmp(OFS_IRQ_CFG, 16'h0001, "irq cfg");
		rd_cmp(OFS_INT_MASK, 16'h0000, "mask");
		rd_cmp(OFS_INT_STATUS, 16'h0000, "status");
		rd_cmp(OFS_PIN_MODE, 16'h0000, "mode");
		rd_cmp(8'h20, 16'h0000, "unmapped");
		@(posedge REF_CLK);
		CLK_EN <= 1'b0;
		reg_wr(OFS_INT_MASK, 16'hffff);
		@(posedge REF_CLK);
		CLK_EN <= 1'b1;
		rd_cmp(OFS_INT_MASK, 16'h0000, "frozen write");
	endtask
	task automatic t_pull();
		for (int c = 0; c < 3; c++) begin
			reg_wr(OFS_PIN2_CTRL, ctl(1, c[1:0], 0, 0, 0, FN_LEVEL_IN));
			cyc(2);
			cmp_bit(PIN_PULL_DOWN[1], c == 1, "pull down");
			cmp_bit(PIN_PULL_UP[1], c == 2, "pull up");
		end
	endtask
	task automatic t_faults();
		@(posedge REF_CLK);
		OVERTEMP <= 1'b1;
		REGULATOR_LOW <= 1'b1;
		cyc(4);
		rd_cmp(OFS_FAULT_FLAGS, 16'h8001, "flags");
		rd_cmp(OFS_INT_STATUS, 16'h8001, "fault status");
		@(posedge REF_CLK);
		REGULATOR_LOW <= 1'b0;
		cyc(4);
		rd_cmp(OFS_FAULT_FLAGS, 16'h8000, "flags low");
		rd_cmp(OFS_INT_STATUS, 16'h0000, "read clears");
	endtask
	task automatic t_outputs();
		logic [3:0] fns [6] = '{FN_LEVEL_OUT, FN_TEMP_OUT, FN_REGLOW_OUT, FN_CLK_OUT,
			FN_MIC_CLK, FN_IRQ_OUT};
		logic [5:0] expv = 6'b001011;
		for (int inv = 0; inv < 2; inv++) begin
			for (int i = 0; i < 6; i++) begin
				reg_wr(OFS_PIN1_CTRL, ctl(0, PULL_NONE, 0, inv[0], 1, fns[i]));
				cyc(3);
				cmp_bit(PIN_OUT[0], expv[i] ^ inv[0], "drive");
				cmp_bit(PIN_OE_N[0], 1'b0, "oe");
			end
		end
		reg_wr(OFS_PIN1_CTRL, ctl(1, PULL_NONE, 0, 0, 1, FN_LEVEL_OUT));
		cyc(3);
		cmp_bit(PIN_OE_N[0], 1'b1, "input dir");
	endtask
	task automatic t_edges();
		reg_wr(OFS_IRQ_CFG, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			reg_wr(OFS_PIN1_CTRL, ctl(1, PULL_NONE, k[1], k[0], 0, FN_EDGE_IN));
			cyc(3);
			// invert change may raise one spurious edge; a plain read drops it
			reg_rd(OFS_INT_STATUS);
			set_pin(0, 1'b1);
			rd_cmp(OFS_INT_STATUS, {4'h0, k[1] | !k[0], 11'h0}, "rise");
			set_pin(0, 1'b0);
			rd_cmp(OFS_INT_STATUS, {4'h0, k[1] | k[0], 11'h0}, "fall");
		end
	endtask
	task automatic t_irq();
		reg_wr(OFS_PIN2_CTRL, ctl(0, PULL_NONE, 0, 0, 0, FN_IRQ_OUT));
		set_pin(0, 1'b1);
		cmp_bit(IRQ, 1'b1, "irq");
		cmp_bit(PIN_OUT[1], 1'b1, "irq pin");
		rd_cmp(OFS_INT_STATUS, 16'h0800, "pin status");
		cyc(2);
		cmp_bit(IRQ, 1'b0, "irq cleared");
		reg_wr(OFS_INT_MASK, 16'h0800);
		set_pin(0, 1'b0);
		cmp_bit(IRQ, 1'b0, "source masked");
		reg_wr(OFS_INT_MASK, 16'hffff);
		rd_cmp(OFS_INT_MASK, 16'hf801, "mask bits");
		cmp_bit(IRQ, 1'b0, "all masked");
		reg_wr(OFS_INT_MASK, 16'h0000);
		cyc(3);
		cmp_bit(IRQ, 1'b1, "unmasked");
		reg_wr(OFS_IRQ_CFG, 16'h0001);
		cyc(3);
		cmp_bit(IRQ, 1'b0, "global mask");
		rd_cmp(OFS_INT_STATUS, 16'h0800, "masked status");
	endtask
	task automatic t_level();
		reg_wr(OFS_PIN4_CTRL, ctl(1, PULL_NONE, 0, 0, 0, FN_LEVEL_IN));
		set_pin(3, 1'b1);
		tick();
		rd_cmp(OFS_PIN4_CTRL, 16'h8000, "no timeout clock");
		@(posedge REF_CLK);
		TIMEOUT_CLOCK_ENABLE <= 1'b1;
		tick();
		rd_cmp(OFS_PIN4_CTRL, 16'h8020, "level read");
		reg_wr(OFS_PIN4_CTRL, ctl(1, PULL_NONE, 0, 1, 0, FN_LEVEL_IN));
		tick();
		rd_cmp(OFS_PIN4_CTRL, 16'h8400, "inverted read");
	endtask
	task automatic t_mode();
		@(posedge REF_CLK);
		ext_en[2] <= 1'b1;
		set_pin(2, 1'b1);
		cmp_bit(CONTROL_PORT_MODE_PIN, 1'b1, "mode strap");
		reg_wr(OFS_PIN3_CTRL, ctl(0, PULL_NONE, 0, 0, 1, FN_LEVEL_OUT));
		cyc(3);
		cmp_bit(PIN_OE_N[2], 1'b1, "pin3 held");
		reg_wr(OFS_PIN_MODE, 16'h0001);
		reg_wr(OFS_PIN_MODE, 16'h0000);
		cyc(3);
		rd_cmp(OFS_PIN_MODE, 16'h0001, "mode latched");
		cmp_bit(PIN_OE_N[2], 1'b0, "pin3 drives");
		cmp_bit(CONTROL_PORT_MODE_PIN, 1'b0, "strap released");
		@(posedge REF_CLK);
		SOFT_RESET <= 1'b1;
		@(posedge REF_CLK);
		SOFT_RESET <= 1'b0;
		rd_cmp(OFS_PIN_MODE, 16'h0000, "soft reset");
	endtask
	// ********************************
	// main sequence
	// ********************************
	initial begin
		RST_N = 1'b0;
		CLK_EN = 1'b1;
		SOFT_RESET = 1'b0;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 16'h0000;
		OVERTEMP = 1'b0;
		REGULATOR_LOW = 1'b0;
		DIVIDED_CLOCK = 1'b1;
		MIC_CLOCK = 1'b0;
		TIMEOUT_CLOCK_ENABLE = 1'b0;
		SLOW_TICK = 1'b0;
		ext_en = 4'h9;
		ext_val = 4'h0;
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		t_reset();
		t_pull();
		t_faults();
		t_outputs();
		t_edges();
		t_irq();
		t_level();
		t_mode();
		complete_run();
	end
endmodule
